// ---- logic/digital_port_access_logic.v ----
// Digital port access logic: pin/latch views for data-memory instructions
//
// Summary of operation
// - Input mode: loads and tests see pins
// - Input mode: accumulator store fills latch only
// - Input mode: exchange takes pins, latches accumulator
// - Input mode: increment stores pins plus one
// - Input mode: bit writes, other bits of the nibble copied from pins
// - Output mode: loads and tests see latch
// - Output mode: accumulator store latches and drives
// - Output mode: exchange swaps latch, drives result
// - Output mode: increment latch, drive new value
// - Output mode: bit write changes only that bit
// - Carry operations use pin or latch bit
// - Compare and arithmetic use pin or latch
`timescale 1ns/1ps
`include "port_access_map.vh"

module digital_port_access_logic #(
    parameter WIDTH = `PORT_WIDTH,
    parameter NIB_W = `NIB_WIDTH
) (
    input  wire                 mclk,
    input  wire                 rst_b,
    input  wire                 op_valid,
    input  wire [`OP_WIDTH-1:0] op_code,
    input  wire                 nib_sel,
    input  wire [1:0]           bit_sel,
    input  wire [WIDTH-1:0]     acc_in,
    input  wire                 carry_flag_in,
    input  wire [WIDTH-1:0]     dir_out,
    input  wire [WIDTH-1:0]     pin_in,
    output wire [WIDTH-1:0]     pin_out,
    output wire [WIDTH-1:0]     pin_oe,
    output wire [WIDTH-1:0]     acc_out,
    output wire                 acc_we,
    output wire                 carry_flag_out,
    output wire                 carry_we,
    output wire                 skip,
    output wire                 done
);

    // Reset values sized to the port width
    localparam [WIDTH-1:0] LATCH_INIT = `LATCH_RESET;
    localparam [WIDTH-1:0] ACC_INIT   = `ACC_RESET;
    localparam [WIDTH-1:0] NO_DRIVE   = {WIDTH{1'b0}};

    // Internal bus view: latch for output pins, pin level for input pins
    function [WIDTH-1:0] bus_view;
        input [WIDTH-1:0] latch;
        input [WIDTH-1:0] pins;
        input [WIDTH-1:0] dir;
        begin
            bus_view = (dir & latch) | (~dir & pins);
        end
    endfunction

    // Nibble select high picks the upper 4-bit port
    function [NIB_W-1:0] get_nib;
        input [WIDTH-1:0] word;
        input             sel;
        begin
            if (sel) begin
                get_nib = word[WIDTH-1:NIB_W];
            end else begin
                get_nib = word[NIB_W-1:0];
            end
        end
    endfunction

    // Replaces one nibble and keeps the other
    function [WIDTH-1:0] put_nib;
        input [WIDTH-1:0] word;
        input             sel;
        input [NIB_W-1:0] nib;
        begin
            if (sel) begin
                put_nib = {nib, word[NIB_W-1:0]};
            end else begin
                put_nib = {word[WIDTH-1:NIB_W], nib};
            end
        end
    endfunction

    // Rewrites one bit of a nibble, the rest pass through
    function [NIB_W-1:0] put_bit;
        input [NIB_W-1:0] nib;
        input [1:0]       idx;
        input             val;
        reg   [NIB_W-1:0] tmp;
        begin
            tmp      = nib;
            tmp[idx] = val;
            put_bit  = tmp;
        end
    endfunction

    // Nibble results reach the accumulator with the upper bits cleared
    function [WIDTH-1:0] widen_nib;
        input [NIB_W-1:0] nib;
        begin
            widen_nib = {{(WIDTH-NIB_W){1'b0}}, nib};
        end
    endfunction

    wire [WIDTH-1:0]  pin_s;

    reg  [WIDTH-1:0]  latch_r;
    reg  [WIDTH-1:0]  latch_nxt;
    reg  [WIDTH-1:0]  oe_r;
    reg  [WIDTH-1:0]  acc_r;
    reg  [WIDTH-1:0]  acc_nxt;
    reg               acc_we_r;
    reg               acc_we_nxt;
    reg               carry_r;
    reg               carry_nxt;
    reg               carry_we_r;
    reg               carry_we_nxt;
    reg               skip_r;
    reg               skip_nxt;
    reg               done_r;

    wire [WIDTH-1:0]  view;
    wire [NIB_W-1:0]  view_nib;
    wire              view_bit;
    wire [NIB_W-1:0]  acc_nib;
    wire [NIB_W:0]    add_sum;
    wire [NIB_W-1:0]  inc_nib;

    // Pins come from outside the clock domain
    pin_sync #(
        .WIDTH (WIDTH)
    ) u_pin_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (pin_in),
        .q     (pin_s)
    );

    // Direction is same-clock and read as is; pins arrive two edges late
    assign view     = bus_view(latch_r, pin_s, dir_out);
    assign view_nib = get_nib(view, nib_sel);
    assign view_bit = view_nib[bit_sel];
    assign acc_nib  = acc_in[NIB_W-1:0];
    assign add_sum  = {1'b0, acc_nib} + {1'b0, view_nib};
    assign inc_nib  = view_nib + {{(NIB_W-1){1'b0}}, 1'b1};

    // One op per cycle; each op sees the latch left by the one before
    always @* begin
        latch_nxt    = latch_r;
        acc_nxt      = acc_r;
        acc_we_nxt   = 1'b0;
        carry_nxt    = carry_r;
        carry_we_nxt = 1'b0;
        skip_nxt     = 1'b0;
        if (op_valid) begin
            case (op_code)
                // Reads: the accumulator takes the bus view
                `OP_LOAD_NIB: begin
                    acc_nxt    = widen_nib(view_nib);
                    acc_we_nxt = 1'b1;
                end
                `OP_LOAD_BYTE: begin
                    acc_nxt    = view;
                    acc_we_nxt = 1'b1;
                end

                // Writes: latch only, the driver follows direction
                `OP_STORE_NIB: begin
                    latch_nxt = put_nib(latch_r, nib_sel, acc_nib);
                end
                `OP_STORE_BYTE: begin
                    latch_nxt = acc_in;
                end
                `OP_EXCHANGE_NIB: begin
                    acc_nxt    = widen_nib(view_nib);
                    acc_we_nxt = 1'b1;
                    latch_nxt  = put_nib(latch_r, nib_sel, acc_nib);
                end
                `OP_EXCHANGE_BYTE: begin
                    acc_nxt    = view;
                    acc_we_nxt = 1'b1;
                    latch_nxt  = acc_in;
                end

                // Skip when the nibble wraps to zero
                `OP_INCREMENT_SKIP: begin
                    latch_nxt = put_nib(latch_r, nib_sel, inc_nib);
                    skip_nxt  = (inc_nib == {NIB_W{1'b0}});
                end

                // Tests answer with a skip pulse; test-and-clear also clears the bit in the latch
                `OP_SKIP_BIT_TRUE: begin
                    skip_nxt = view_bit;
                end
                `OP_SKIP_BIT_FALSE: begin
                    skip_nxt = ~view_bit;
                end
                `OP_TEST_CLEAR_BIT: begin
                    skip_nxt  = view_bit;
                    // Other bits of the nibble rewritten from the bus view
                    latch_nxt = put_nib(latch_r, nib_sel,
                        put_bit(view_nib, bit_sel, 1'b0));
                end
                `OP_BIT_SET: begin
                    latch_nxt = put_nib(latch_r, nib_sel,
                        put_bit(view_nib, bit_sel, 1'b1));
                end
                `OP_BIT_CLEAR: begin
                    latch_nxt = put_nib(latch_r, nib_sel,
                        put_bit(view_nib, bit_sel, 1'b0));
                end
                `OP_BIT_FROM_CARRY: begin
                    latch_nxt = put_nib(latch_r, nib_sel,
                        put_bit(view_nib, bit_sel, carry_flag_in));
                end

                // Carry operations use one bit of the view
                `OP_BIT_TO_CARRY: begin
                    carry_nxt    = view_bit;
                    carry_we_nxt = 1'b1;
                end
                `OP_CARRY_AND: begin
                    carry_nxt    = carry_flag_in & view_bit;
                    carry_we_nxt = 1'b1;
                end
                `OP_CARRY_OR: begin
                    carry_nxt    = carry_flag_in | view_bit;
                    carry_we_nxt = 1'b1;
                end
                `OP_CARRY_XOR: begin
                    carry_nxt    = carry_flag_in ^ view_bit;
                    carry_we_nxt = 1'b1;
                end

                // Compares skip on equality
                `OP_COMPARE_NIB: begin
                    skip_nxt = (acc_nib == view_nib);
                end
                `OP_COMPARE_BYTE: begin
                    skip_nxt = (acc_in == view);
                end
                // Carry out of the nibble asks for a skip
                `OP_ADD_SKIP: begin
                    acc_nxt    = widen_nib(add_sum[NIB_W-1:0]);
                    acc_we_nxt = 1'b1;
                    skip_nxt   = add_sum[NIB_W];
                end
                `OP_ACC_AND: begin
                    acc_nxt    = widen_nib(acc_nib & view_nib);
                    acc_we_nxt = 1'b1;
                end
                `OP_ACC_OR: begin
                    acc_nxt    = widen_nib(acc_nib | view_nib);
                    acc_we_nxt = 1'b1;
                end
                `OP_ACC_XOR: begin
                    acc_nxt    = widen_nib(acc_nib ^ view_nib);
                    acc_we_nxt = 1'b1;
                end

                // Unknown codes answer with done alone
                default: begin
                    latch_nxt = latch_r;
                end
            endcase
        end
    end

    // Latch keeps its value across a direction change, so a pin switched
    // to output drives whatever was stored while it was an input
    always @(posedge mclk) begin
        if (!rst_b) begin
            latch_r    <= LATCH_INIT;
            oe_r       <= NO_DRIVE;
            acc_r      <= ACC_INIT;
            acc_we_r   <= 1'b0;
            carry_r    <= 1'b0;
            carry_we_r <= 1'b0;
            skip_r     <= 1'b0;
            done_r     <= 1'b0;
        end else begin
            latch_r    <= latch_nxt;
            oe_r       <= dir_out;
            acc_r      <= acc_nxt;
            acc_we_r   <= acc_we_nxt;
            carry_r    <= carry_nxt;
            carry_we_r <= carry_we_nxt;
            skip_r     <= skip_nxt;
            // Done answers every taken op, unknown codes too
            done_r     <= op_valid;
        end
    end

    // Driver enable never follows the operation, only the direction
    assign pin_out        = latch_r;
    assign pin_oe         = oe_r;
    assign acc_out        = acc_r;
    assign acc_we         = acc_we_r;
    assign carry_flag_out = carry_r;
    assign carry_we       = carry_we_r;
    assign skip           = skip_r;
    assign done           = done_r;

endmodule

// ---- logic/port_access_map.vh ----
// Operation codes, widths and reset values for the port access logic
`ifndef PORT_ACCESS_MAP_VH
`define PORT_ACCESS_MAP_VH

// Port geometry
`define PORT_WIDTH          8
`define NIB_WIDTH           4
`define OP_WIDTH            5

// Reset values
`define LATCH_RESET         8'h00
`define ACC_RESET           8'h00

// Operation codes
`define OP_NOP              5'h00
`define OP_LOAD_NIB         5'h01
`define OP_LOAD_BYTE        5'h02
`define OP_STORE_NIB        5'h03
`define OP_STORE_BYTE       5'h04
`define OP_EXCHANGE_NIB     5'h05
`define OP_EXCHANGE_BYTE    5'h06
`define OP_INCREMENT_SKIP   5'h07
`define OP_SKIP_BIT_TRUE    5'h08
`define OP_SKIP_BIT_FALSE   5'h09
`define OP_TEST_CLEAR_BIT   5'h0A
`define OP_BIT_SET          5'h0B
`define OP_BIT_CLEAR        5'h0C
`define OP_BIT_FROM_CARRY   5'h0D
`define OP_BIT_TO_CARRY     5'h0E
`define OP_CARRY_AND        5'h0F
`define OP_CARRY_OR         5'h10
`define OP_CARRY_XOR        5'h11
`define OP_COMPARE_NIB      5'h12
`define OP_COMPARE_BYTE     5'h13
`define OP_ADD_SKIP         5'h14
`define OP_ACC_AND          5'h15
`define OP_ACC_OR           5'h16
`define OP_ACC_XOR          5'h17

`endif

// ---- logic/pin_sync.v ----
// Two-stage synchroniser for the port pin levels
`timescale 1ns/1ps

module pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             mclk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);

    genvar i;

    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_r;
            reg sync_r;
            always @(posedge mclk) begin
                if (!rst_b) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= d[i];
                    sync_r <= meta_r;
                end
            end
            assign q[i] = sync_r;
        end
    endgenerate

endmodule

// ---- verification/port_access_checker.sv ----
// Checker for the port access logic
`timescale 1ns/1ps
`include "port_access_map.vh"
module port_access_checker (
    input wire       mclk,
    input wire       rst_b,
    input wire       op_valid,
    input wire [4:0] op_code,
    input wire       nib_sel,
    input wire [1:0] bit_sel,
    input wire [7:0] acc_in,
    input wire [7:0] dir_out,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] acc_out,
    input wire       acc_we,
    input wire       carry_we,
    input wire       skip,
    input wire       done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_done_follows: assert property (op_valid |=> done)
        else $error("done missing after op");
    a_idle_quiet: assert property (!op_valid |=> !done && !acc_we)
        else $error("pulse without op");
    a_pulse_done: assert property ((carry_we || skip) |-> done)
        else $error("result pulse without done");
    a_oe_follows: assert property (1'b1 |=> pin_oe == $past(dir_out))
        else $error("driver enable not from direction");
    a_store_latch: assert property (op_valid &&
        op_code == `OP_STORE_BYTE |=> pin_out == $past(acc_in))
        else $error("store did not latch");
    a_load_latch: assert property (op_valid &&
        op_code == `OP_LOAD_BYTE && dir_out == 8'hFF
        |=> acc_we && acc_out == $past(pin_out))
        else $error("load not from latch");
    a_exchange_swap: assert property (op_valid &&
        op_code == `OP_EXCHANGE_BYTE && dir_out == 8'hFF
        |=> acc_out == $past(pin_out) && pin_out == $past(acc_in))
        else $error("exchange wrong");
    a_inc_high: assert property (op_valid && nib_sel &&
        op_code == `OP_INCREMENT_SKIP && dir_out == 8'hFF
        |=> pin_out == $past(pin_out) + 8'h10)
        else $error("increment wrong");
    a_bit_set: assert property (op_valid &&
        op_code == `OP_BIT_SET && dir_out == 8'hFF
        |=> pin_out == ($past(pin_out) |
        (8'h01 << {$past(nib_sel), $past(bit_sel)})))
        else $error("bit set wrong");
endmodule
bind digital_port_access_logic port_access_checker i_chk (.*);

// ---- verification/pin_partner.sv ----
// Model of the circuitry on the port pins
`timescale 1ns/1ps
module pin_partner (
    input  wire [7:0] pin_out,
    input  wire [7:0] pin_oe,
    input  wire [7:0] ext_val,
    output wire [7:0] pin_in
);
    // Driven pins show the latch, released ones the outside level
    assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule

// ---- verification/digital_port_access_logic_tb.sv ----
// Self-checking bench for the port access logic
`timescale 1ns/1ps
`include "port_access_map.vh"
module digital_port_access_logic_tb;
    reg        mclk = 1'b0;
    reg        rst_b = 1'b0;
    reg        op_valid = 1'b0;
    reg  [4:0] op_code = 5'h00;
    reg        nib_sel = 1'b0;
    reg  [1:0] bit_sel = 2'h0;
    reg  [7:0] acc_in = 8'h00;
    reg        carry_in = 1'b0;
    reg  [7:0] dir_out = 8'h00;
    reg  [7:0] ext_val = 8'h00;
    wire [7:0] pin_in, pin_out, pin_oe, acc_out;
    wire       acc_we, carry_out, carry_we, skip, done;
    int        n_mismatch = 0;
    int        compares = 0;

    always #25 mclk = ~mclk;

    digital_port_access_logic i_dut (.mclk(mclk), .rst_b(rst_b),
        .op_valid(op_valid), .op_code(op_code), .nib_sel(nib_sel),
        .bit_sel(bit_sel), .acc_in(acc_in), .carry_flag_in(carry_in),
        .dir_out(dir_out), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .acc_out(acc_out), .acc_we(acc_we),
        .carry_flag_out(carry_out), .carry_we(carry_we), .skip(skip),
        .done(done));
    pin_partner i_pins (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_val(ext_val), .pin_in(pin_in));

    task chk(input [7:0] got, input [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // nb packs the nibble select above the bit index
    task op(input [4:0] c, input [2:0] nb, input [7:0] a, input cf);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= c;
        {nib_sel, bit_sel} <= nb;
        acc_in <= a;
        carry_in <= cf;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
        chk(8'(done), 8'h01);
    endtask

    task setup(input [7:0] d, input [7:0] e);
        @(posedge mclk);
        dir_out <= d;
        ext_val <= e;
        // Pin levels need the synchroniser to fill
        repeat (3) @(posedge mclk);
    endtask

    task t_input;
        setup(8'h00, 8'hA5);
        op(`OP_LOAD_BYTE, 3'h0, 8'h00, 1'b0);
        chk(acc_out, 8'hA5);
        op(`OP_SKIP_BIT_TRUE, 3'h5, 8'h00, 1'b0);
        chk(8'(skip), 8'h01);
        op(`OP_STORE_BYTE, 3'h0, 8'h3C, 1'b0);
        chk(pin_out, 8'h3C);
        op(`OP_EXCHANGE_BYTE, 3'h0, 8'h5A, 1'b0);
        chk(acc_out, 8'hA5);
        chk(pin_out, 8'h5A);
        op(`OP_INCREMENT_SKIP, 3'h0, 8'h00, 1'b0);
        chk(8'(pin_out[3:0]), 8'h06);
        op(`OP_BIT_SET, 3'h3, 8'h00, 1'b0);
        chk(8'(pin_out[3]), 8'h01);
        chk(pin_oe, 8'h00);
        $display("t_input finished");
    endtask

    task t_output;
        setup(8'hFF, 8'h00);
        op(`OP_STORE_BYTE, 3'h0, 8'h0F, 1'b0);
        chk(pin_out, 8'h0F);
        chk(pin_oe, 8'hFF);
        op(`OP_LOAD_BYTE, 3'h0, 8'h00, 1'b0);
        chk(acc_out, 8'h0F);
        op(`OP_EXCHANGE_BYTE, 3'h0, 8'h81, 1'b0);
        chk(acc_out, 8'h0F);
        op(`OP_INCREMENT_SKIP, 3'h4, 8'h00, 1'b0);
        chk(pin_out, 8'h91);
        op(`OP_BIT_SET, 3'h2, 8'h00, 1'b0);
        op(`OP_BIT_CLEAR, 3'h7, 8'h00, 1'b0);
        op(`OP_BIT_FROM_CARRY, 3'h1, 8'h00, 1'b1);
        chk(pin_out, 8'h17);
        op(`OP_SKIP_BIT_FALSE, 3'h3, 8'h00, 1'b0);
        chk(8'(skip), 8'h01);
        op(`OP_TEST_CLEAR_BIT, 3'h0, 8'h00, 1'b0);
        chk({skip, pin_out[6:0]}, 8'h96);
        op(5'h1F, 3'h0, 8'h00, 1'b0);
        chk({acc_we, pin_out[6:0]}, 8'h16);
        $display("t_output finished");
    endtask

    // Low nibble drives, high nibble listens: view is 6A
    task t_mixed;
        setup(8'h0F, 8'h69);
        op(`OP_STORE_BYTE, 3'h0, 8'h5A, 1'b0);
        op(`OP_BIT_TO_CARRY, 3'h5, 8'h00, 1'b0);
        chk({carry_we, carry_out}, 8'h03);
        op(`OP_CARRY_AND, 3'h0, 8'h00, 1'b1);
        chk(8'(carry_out), 8'h00);
        op(`OP_CARRY_OR, 3'h1, 8'h00, 1'b0);
        chk(8'(carry_out), 8'h01);
        op(`OP_CARRY_XOR, 3'h6, 8'h00, 1'b1);
        chk(8'(carry_out), 8'h00);
        op(`OP_COMPARE_NIB, 3'h4, 8'h06, 1'b0);
        chk(8'(skip), 8'h01);
        op(`OP_COMPARE_BYTE, 3'h0, 8'h6A, 1'b0);
        chk(8'(skip), 8'h01);
        op(`OP_ADD_SKIP, 3'h0, 8'h08, 1'b0);
        chk({skip, acc_out[6:0]}, 8'h82);
        op(`OP_ACC_AND, 3'h4, 8'h0C, 1'b0);
        chk(acc_out, 8'h04);
        op(`OP_ACC_OR, 3'h0, 8'h05, 1'b0);
        chk(acc_out, 8'h0F);
        op(`OP_ACC_XOR, 3'h4, 8'h03, 1'b0);
        chk(acc_out, 8'h05);
        op(`OP_LOAD_NIB, 3'h4, 8'h00, 1'b0);
        chk(acc_out, 8'h06);
        op(`OP_STORE_NIB, 3'h4, 8'h03, 1'b0);
        chk(pin_out, 8'h3A);
        chk(pin_oe, 8'h0F);
        op(`OP_EXCHANGE_NIB, 3'h0, 8'h0C, 1'b0);
        chk(acc_out, 8'h0A);
        chk(pin_out, 8'h3C);
        op(`OP_EXCHANGE_NIB, 3'h4, 8'h05, 1'b0);
        chk({acc_out[3:0], pin_out[7:4]}, 8'h65);
        $display("t_mixed finished");
    endtask

    task tally_and_finish;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        t_input;
        t_output;
        t_mixed;
        tally_and_finish;
    end

    initial begin
        repeat (2000) @(posedge mclk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
